/* File: rtl/supply_pulse_fuse_programmer.sv */
`timescale 1ns/10ps
`include "fuse_prog_consts.svh"
module supply_pulse_fuse_programmer
    import fuse_prog_pkg::*;
#(
    parameter int BLOW_CYCLES = `T_BLOW_CYC
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SUPPLY_ABOVE_MID,
    input wire logic SUPPLY_ABOVE_HIGH,
    input wire logic [6:0] FUSE_SENSE,
    output logic [5:0] OPERATE_THRESHOLD,
    output logic FUSE_CHECK_LOW,
    output logic FUSE_CHECK_HIGH,
    output logic BLOW_STROBE,
    output logic [6:0] BLOW_SELECT,
    output logic LOCKED,
    output logic TRIAL_MODE,
    output logic BLOW_MODE
);

    initial begin
        if (BLOW_CYCLES <= `T_ACTIVE_CYC || BLOW_CYCLES > 65535) begin
            $error("supply_pulse_fuse_programmer: bad BLOW_CYCLES");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [5:0] sat_inc(input logic [5:0] v);
        sat_inc = (v == `FIELD_MAX) ? v : v + 6'h01;
    endfunction

    // Code to trim field; down-trim inverts
    function automatic logic [5:0] map_code(input logic [3:0] k,
                                            input logic [5:0] c);
        map_code = (k == `KEY_TRIM_DOWN) ? ~c : c;
    endfunction

    pulse_ev_s ev;
    logic blow_hit;
    blow_req_s blow_d;
    logic [6:0] fuses;
    prog_state_e state_q;
    logic [5:0] key_cnt_q, mid_cnt_q, code_q, addr_q, trial_q;
    logic [3:0] key_q;
    logic chk_low_q, chk_high_q;
    logic ev_mid, ev_high, locked, trim_key, sel_refused;
    logic [3:0] key_now;

    assign ev_mid = ev.valid && !ev.high;
    assign ev_high = ev.valid && ev.high;
    assign locked = fuses[`LOCK_FUSE_POS];
    assign key_now = (key_cnt_q > 6'h0F) ? 4'hF : key_cnt_q[3:0];
    assign trim_key = (key_q == `KEY_TRIM_UP) || (key_q == `KEY_TRIM_DOWN);
    assign sel_refused = locked && (key_now != `KEY_FUSE_CHECK);

    ////////////////////////////////////////////////////////////////////
    // Pulse decoding and fuse storage
    pulse_classifier #(
        .ACTIVE_CYCLES(`T_ACTIVE_CYC),
        .BLOW_CYCLES(BLOW_CYCLES)
    ) u_classifier (
        .clk(MCLK),
        .rst(RST),
        .above_mid(SUPPLY_ABOVE_MID),
        .above_high(SUPPLY_ABOVE_HIGH),
        .ev(ev),
        .blow_hit(blow_hit)
    );

    fuse_bank u_fuses (
        .clk(MCLK),
        .rst(RST),
        .sense(FUSE_SENSE),
        .blow(blow_d),
        .fuses(fuses),
        .strobe(BLOW_STROBE),
        .select(BLOW_SELECT)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequence state
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (ev_high) begin
                        state_q <= ST_KEY;
                    end
                end
                ST_KEY: begin
                    if (ev_high) begin
                        state_q <= sel_refused ? ST_DONE : ST_TRY;
                    end
                end
                ST_TRY: begin
                    if (ev_high) begin
                        if (mid_cnt_q == `KEY_BLOW_MODE &&
                            (trim_key || key_q == `KEY_FUSE_CHECK)) begin
                            state_q <= ST_BLOW;
                        end else begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_BLOW: begin
                    if (blow_hit) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Mid pulses between the selection highs
    always_ff @(posedge MCLK) begin
        if (RST || state_q == ST_IDLE) begin
            key_cnt_q <= 6'h00;
        end else if (state_q == ST_KEY && ev_mid) begin
            key_cnt_q <= sat_inc(key_cnt_q);
        end
    end

    // Latched key; no mids gives key zero
    always_ff @(posedge MCLK) begin
        if (RST) begin
            key_q <= 4'h0;
        end else if (state_q == ST_KEY && ev_high) begin
            key_q <= key_now;
        end
    end

    // Mids after selection, used for mode key
    always_ff @(posedge MCLK) begin
        if (RST || state_q == ST_KEY) begin
            mid_cnt_q <= 6'h00;
        end else if (state_q == ST_TRY && ev_mid) begin
            mid_cnt_q <= sat_inc(mid_cnt_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trial code and applied trial field
    always_ff @(posedge MCLK) begin
        if (RST) begin
            code_q <= 6'h00;
        end else if (state_q == ST_KEY && ev_high) begin
            if (key_now == `KEY_TRIM_UP || key_now == `KEY_TRIM_DOWN) begin
                code_q <= `TRIM_START_CODE;
            end else begin
                code_q <= 6'h00;
            end
        end else if (state_q == ST_TRY && ev_mid) begin
            code_q <= sat_inc(code_q);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            trial_q <= `TRIM_RESET;
        end else if (state_q == ST_KEY && ev_high && !sel_refused &&
                     (key_now == `KEY_TRIM_UP ||
                      key_now == `KEY_TRIM_DOWN)) begin
            trial_q <= map_code(key_now, `TRIM_START_CODE);
        end else if (state_q == ST_TRY && ev_mid && trim_key) begin
            trial_q <= map_code(key_q, sat_inc(code_q));
        end
    end

    // Fuse check levels while key 7 is tried
    always_ff @(posedge MCLK) begin
        if (RST) begin
            chk_low_q <= 1'b0;
            chk_high_q <= 1'b0;
        end else begin
            chk_low_q <= state_q == ST_TRY &&
                key_q == `KEY_FUSE_CHECK &&
                code_q == `CHECK_LOW_CODE;
            chk_high_q <= state_q == ST_TRY &&
                key_q == `KEY_FUSE_CHECK &&
                code_q == `CHECK_HIGH_CODE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Blow addressing, one-hot shift
    always_ff @(posedge MCLK) begin
        if (RST || state_q != ST_BLOW) begin
            addr_q <= 6'h00;
        end else if (ev_mid) begin
            addr_q <= (addr_q == 6'h00) ? 6'h01 : addr_q << 1;
        end
    end

    // One blow per sequence, gated by register and lock
    always_comb begin
        blow_d = '0;
        if (state_q == ST_BLOW && blow_hit && addr_q != 6'h00) begin
            if (trim_key) begin
                blow_d.req = 1'b1;
                blow_d.sel = {1'b0, addr_q};
            end else if (addr_q == `LOCK_ADDR && !locked) begin
                blow_d.req = 1'b1;
                blow_d.sel = 7'h40;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge MCLK) begin
        if (RST) begin
            OPERATE_THRESHOLD <= `TRIM_RESET;
            LOCKED <= 1'b0;
            TRIAL_MODE <= 1'b0;
            BLOW_MODE <= 1'b0;
        end else begin
            OPERATE_THRESHOLD <= trial_q | fuses[5:0];
            LOCKED <= locked;
            TRIAL_MODE <= state_q == ST_TRY;
            BLOW_MODE <= state_q == ST_BLOW;
        end
    end

    assign FUSE_CHECK_LOW = chk_low_q;
    assign FUSE_CHECK_HIGH = chk_high_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_select_close;
        state_q == ST_KEY && ev_high;
    endsequence

    sequence s_try_mid;
        state_q == ST_TRY && ev_mid;
    endsequence

    chk_idle_start: assert property (
        $past(RST) |-> state_q == ST_IDLE && code_q == 6'h00)
        else $error("decoder not idle after reset");
    chk_key_count: assert property (
        state_q == ST_KEY && ev_mid && key_cnt_q != `FIELD_MAX
        |=> key_cnt_q == $past(key_cnt_q) + 6'h01)
        else $error("key mid not counted");
    chk_key_zero: assert property (
        s_select_close and key_cnt_q == 6'h00 |=> key_q == 4'h0)
        else $error("adjacent highs not key zero");
    chk_try_default: assert property (
        s_select_close and !sel_refused |=> state_q == ST_TRY)
        else $error("selection did not enter trial mode");
    chk_trim_start: assert property (
        s_select_close and key_now == `KEY_TRIM_UP && !sel_refused
        |=> code_q == 6'h01 && trial_q == 6'h01 ##2
        OPERATE_THRESHOLD[0])
        else $error("up trim did not start at code one");
    chk_code_step: assert property (
        s_try_mid and code_q != `FIELD_MAX
        |=> code_q == $past(code_q) + 6'h01)
        else $error("trial code did not step");
    chk_down_invert: assert property (
        s_try_mid and key_q == `KEY_TRIM_DOWN
        |=> trial_q == ~code_q)
        else $error("down trim not inverted");
    chk_blow_key: assert property (
        state_q == ST_TRY && ev_high && mid_cnt_q == 6'h09 && trim_key
        |=> state_q == ST_BLOW ##1 BLOW_MODE)
        else $error("blow key not recognised");
    chk_onehot_addr: assert property (
        state_q == ST_BLOW |-> $onehot0(addr_q))
        else $error("blow address not one-hot");
    chk_single_blow: assert property (
        blow_d.req |-> $onehot(blow_d.sel) ##1
        state_q == ST_DONE && !blow_d.req)
        else $error("more than one blow per sequence");
    chk_lock_refuse: assert property (
        s_select_close and locked && key_now != `KEY_FUSE_CHECK
        |=> state_q == ST_DONE)
        else $error("locked device accepted a register");
    chk_fuse_check: assert property (
        state_q == ST_TRY && key_q == `KEY_FUSE_CHECK &&
        code_q == `CHECK_HIGH_CODE |=> FUSE_CHECK_HIGH && !FUSE_CHECK_LOW)
        else $error("high fuse check not raised");

endmodule // supply_pulse_fuse_programmer

/* File: rtl/fuse_prog_consts.svh */
// Offsets, field positions, reset values and timing counts of the programmer
`ifndef FUSE_PROG_CONSTS_SVH
`define FUSE_PROG_CONSTS_SVH

// Clock rate and pulse timing
`define CLK_MHZ 125
`define T_ACTIVE_US 20
`define T_BLOW_US 90
`define T_ACTIVE_CYC (`T_ACTIVE_US * `CLK_MHZ)
`define T_BLOW_CYC (`T_BLOW_US * `CLK_MHZ)

// Register keys and the blow mode key
`define KEY_TRIM_UP 4'h0
`define KEY_TRIM_DOWN 4'h1
`define KEY_FUSE_CHECK 4'h7
`define KEY_BLOW_MODE 6'h09

// Field layout and codes
`define FIELD_W 6
`define FIELD_MAX 6'h3F
`define TRIM_RESET 6'h00
`define TRIM_START_CODE 6'h01
`define CHECK_LOW_CODE 6'h07
`define CHECK_HIGH_CODE 6'h0F
`define LOCK_ADDR 6'h08
`define LOCK_FUSE_POS 6

`endif

/* File: rtl/fuse_prog_pkg.sv */
// Types shared by the fuse programmer modules
package fuse_prog_pkg;

    typedef struct packed {
        logic valid;
        logic high;
    } pulse_ev_s;

    typedef struct packed {
        logic req;
        logic [6:0] sel;
    } blow_req_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_KEY = 5'h02,
        ST_TRY = 5'h04,
        ST_BLOW = 5'h08,
        ST_DONE = 5'h10
    } prog_state_e;

endpackage

/* File: rtl/pulse_classifier.sv */
// Supply level synchroniser and pulse width classifier
`timescale 1ns/10ps
`include "fuse_prog_consts.svh"
module pulse_classifier
    import fuse_prog_pkg::*;
#(
    parameter int ACTIVE_CYCLES = `T_ACTIVE_CYC,
    parameter int BLOW_CYCLES = `T_BLOW_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic above_mid,
    input wire logic above_high,
    output pulse_ev_s ev,
    output logic blow_hit
);

    initial begin
        if (ACTIVE_CYCLES < 2 || BLOW_CYCLES <= ACTIVE_CYCLES ||
            BLOW_CYCLES > 65535) begin
            $error("pulse_classifier: bad cycle counts");
        end
    end

    localparam logic [15:0] ACT_N = 16'(ACTIVE_CYCLES);
    localparam logic [15:0] BLOW_N = 16'(BLOW_CYCLES);

    logic mid_meta_q, mid_s_q, high_meta_q, high_s_q;
    logic [15:0] act_cnt_q, hi_cnt_q;
    pulse_ev_s ev_q;
    logic blow_hit_q;
    logic lvl_low;

    ////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers on the comparator outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            mid_meta_q <= 1'b0;
            mid_s_q <= 1'b0;
            high_meta_q <= 1'b0;
            high_s_q <= 1'b0;
        end else begin
            mid_meta_q <= above_mid;
            mid_s_q <= mid_meta_q;
            high_meta_q <= above_high;
            high_s_q <= high_meta_q;
        end
    end

    assign lvl_low = !mid_s_q && !high_s_q;

    ////////////////////////////////////////////////////////////////////
    // Width counters, saturating
    always_ff @(posedge clk) begin
        if (rst || lvl_low) begin
            act_cnt_q <= 16'h0000;
        end else if (act_cnt_q != 16'hFFFF) begin
            act_cnt_q <= act_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !high_s_q) begin
            hi_cnt_q <= 16'h0000;
        end else if (hi_cnt_q != 16'hFFFF) begin
            hi_cnt_q <= hi_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event on return to low; short excursions dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_q <= '0;
        end else begin
            ev_q.valid <= lvl_low && (act_cnt_q >= ACT_N);
            ev_q.high <= lvl_low && (hi_cnt_q >= ACT_N);
        end
    end

    // Long high level reaching the blow width
    always_ff @(posedge clk) begin
        if (rst) begin
            blow_hit_q <= 1'b0;
        end else begin
            blow_hit_q <= high_s_q && (hi_cnt_q == BLOW_N - 16'h0001);
        end
    end

    assign ev = ev_q;
    assign blow_hit = blow_hit_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_short_dropped: assert property (
        lvl_low && act_cnt_q < ACT_N |=> !ev_q.valid)
        else $error("short excursion produced an event");
    chk_blow_width: assert property (
        blow_hit_q |-> $past(hi_cnt_q) == BLOW_N - 16'h0001)
        else $error("blow hit at wrong width");

endmodule // pulse_classifier

/* File: rtl/fuse_bank.sv */
// Fuse sense capture and blow strobe driver
`timescale 1ns/10ps
`include "fuse_prog_consts.svh"
module fuse_bank
    import fuse_prog_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] sense,
    input blow_req_s blow,
    output logic [6:0] fuses,
    output logic strobe,
    output logic [6:0] select
);

    logic [6:0] sense_meta_q, sense_s_q, blown_q, select_q;
    logic strobe_q;

    ////////////////////////////////////////////////////////////////////
    // Sense synchroniser and local record of blows
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_meta_q <= 7'h00;
            sense_s_q <= 7'h00;
        end else begin
            sense_meta_q <= sense;
            sense_s_q <= sense_meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            blown_q <= 7'h00;
        end else if (blow.req) begin
            blown_q <= blown_q | blow.sel;
        end
    end

    // Blown fuses read back set until reset, then only through sense
    assign fuses = sense_s_q | blown_q;

    ////////////////////////////////////////////////////////////////////
    // Blow strobe output
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_q <= 1'b0;
            select_q <= 7'h00;
        end else begin
            strobe_q <= blow.req;
            if (blow.req) begin
                select_q <= blow.sel;
            end
        end
    end

    assign strobe = strobe_q;
    assign select = select_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_blow_strobe: assert property (
        blow.req |=> strobe_q && select_q == $past(blow.sel) &&
        (fuses & select_q) == select_q)
        else $error("blow request not strobed or not kept");
    chk_fuse_sticky: assert property (
        (fuses & $past(fuses)) == $past(fuses))
        else $error("blown fuse cleared");

endmodule // fuse_bank

/* File: verification/supply_programmer_model.sv */
// Behavioural model of the external programmer driving the supply pin
`timescale 1ns/10ps
module supply_programmer_model #(
    parameter int BLOW_CYCLES = 3000
) (
    input wire logic clk,
    output logic above_mid,
    output logic above_high
);
    localparam int MIN_CYC = 2503;

    initial begin
        above_mid = 1'b0;
        above_high = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One excursion, then the low gap
    task automatic send(input logic [1:0] lvl, input int width);
        int gap;
        gap = MIN_CYC + int'($urandom_range(0, 20));
        @(posedge clk);
        above_mid <= 1'b1;
        above_high <= lvl[1];
        repeat (width) @(posedge clk);
        above_mid <= 1'b0;
        above_high <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask

    // Key or code pulse of legal width
    task automatic sym(input logic [1:0] lvl);
        send(lvl, MIN_CYC + int'($urandom_range(0, 20)));
    endtask

    // Register selection: high, mids, high, no break
    task automatic select_key(input int mids);
        sym(2'h2);
        repeat (mids) sym(2'h1);
        sym(2'h2);
    endtask

    // Mode key for blowing: nine mids and a high
    task automatic blow_key();
        repeat (9) sym(2'h1);
        sym(2'h2);
    endtask

    // Blow pulse held past the blow time
    task automatic blow();
        send(2'h2, BLOW_CYCLES + 100);
    endtask

    // Short excursion well under the minimum width
    task automatic noise();
        send(2'h1, 1000);
    endtask
endmodule // supply_programmer_model

/* File: verification/tb.sv */
// Self-checking testbench of the supply pulse fuse programmer
`timescale 1ns/10ps
module tb;
    import fuse_prog_pkg::*;
    localparam int BLOW_CYC = 3000;
    localparam int MAX_CYC = 125000;

    logic mclk;
    logic rst;
    logic above_mid;
    logic above_high;
    logic [6:0] fuse_q = 7'h00;
    logic lock_fuse = 1'b0;
    logic [5:0] threshold;
    logic check_low;
    logic check_high;
    logic blow_strobe;
    logic [6:0] blow_select;
    logic locked;
    logic trial_mode;
    logic blow_mode;
    logic [6:0] sel_seen = 7'h00;
    int strobe_cnt = 0;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    int b;

    ////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    supply_pulse_fuse_programmer #(.BLOW_CYCLES(BLOW_CYC)) i_dut (
        .MCLK(mclk),
        .RST(rst),
        .SUPPLY_ABOVE_MID(above_mid),
        .SUPPLY_ABOVE_HIGH(above_high),
        .FUSE_SENSE(fuse_q | {lock_fuse, 6'h00}),
        .OPERATE_THRESHOLD(threshold),
        .FUSE_CHECK_LOW(check_low),
        .FUSE_CHECK_HIGH(check_high),
        .BLOW_STROBE(blow_strobe),
        .BLOW_SELECT(blow_select),
        .LOCKED(locked),
        .TRIAL_MODE(trial_mode),
        .BLOW_MODE(blow_mode)
    );

    supply_programmer_model #(.BLOW_CYCLES(BLOW_CYC)) i_prog (
        .clk(mclk),
        .above_mid(above_mid),
        .above_high(above_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fuse array, blow capture and timeout
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (blow_strobe === 1'b1) begin
            strobe_cnt <= strobe_cnt + 1;
            sel_seen <= blow_select;
            fuse_q <= fuse_q | blow_select;
        end
        if (cyc == MAX_CYC) begin
            error_cnt = error_cnt + 1;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [5:0] trim_field(input logic down,
                                              input int code);
        logic [5:0] v;
        v = (code > 63) ? 6'h3F : 6'(code);
        return down ? ~v : v;
    endfunction

    task automatic check(input logic [6:0] got, input logic [6:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reset_dut();
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        void'($urandom(46));
        reset_dut();
        check({1'b0, threshold}, 7'h00);
        check({5'h00, trial_mode, blow_mode}, 7'h00);
        // Down trim with noise and random extra mids
        n = int'($urandom_range(0, 1));
        i_prog.select_key(1);
        i_prog.noise();
        repeat (n) i_prog.sym(2'h1);
        check({1'b0, threshold}, {1'b0, trim_field(1'b1, 1 + n)});
        check({6'h00, trial_mode}, 7'h01);
        check({5'h00, check_low, check_high}, 7'h00);
        // Power cycle drops trial value
        reset_dut();
        check({1'b0, threshold}, 7'h00);
        check({6'h00, trial_mode}, 7'h00);
        // Key zero, blow mode, one-hot address, blow
        b = int'($urandom_range(1, 3));
        i_prog.select_key(0);
        check({1'b0, threshold}, {1'b0, trim_field(1'b0, 1)});
        i_prog.blow_key();
        check({6'h00, blow_mode}, 7'h01);
        repeat (b) i_prog.sym(2'h1);
        check(7'(strobe_cnt), 7'h00);
        i_prog.blow();
        check(7'(strobe_cnt), 7'h01);
        check(sel_seen, 7'h01 << (b - 1));
        check({6'h00, blow_mode}, 7'h00);
        check({6'h00, locked}, 7'h00);
        // Blown bit survives power cycle
        reset_dut();
        check({1'b0, threshold}, 7'h01 << (b - 1));
        check(7'(strobe_cnt), 7'h01);
        // Lock fuse read back refuses the trim register
        lock_fuse <= 1'b1;
        i_prog.select_key(0);
        check({6'h00, locked}, 7'h01);
        check({6'h00, trial_mode}, 7'h00);
        check({1'b0, threshold}, 7'h01 << (b - 1));
        check(7'(strobe_cnt), 7'h01);
        give_verdict();
    end
endmodule // tb
